// *** src/pbl_loader.sv ***
`timescale 1ns/1ps
`default_nettype none
module pbl_loader import pbl_pkg::*; #(
  parameter int LATENCY = 4,               // Link clocks from latch to first word
  parameter int HALF    = 4                // Master link clock half period
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic [7:0]        i_addr,         // Register address
  input  wire logic [31:0]       i_wdata,        // Register write data
  input  wire logic              i_wr,           // Write strobe
  input  wire logic              i_rd,           // Read strobe
  output logic [31:0]            o_rdata,        // Read data, cycle after strobe
  input  wire logic              i_ext_clk,      // Free-running link clock
  input  wire logic              i_restart_n,    // Restart pin
  input  wire logic              i_ready_wait,   // Flash ready
  input  wire logic [DATA_W-1:0] i_data,         // Flash data bus
  input  wire logic              i_init_in,      // Init status wire level
  output logic                   o_init_oe_n,    // Low pulls init low
  input  wire logic              i_done_in,      // Done wire level
  output logic                   o_done_oe_n,    // Low pulls done low
  output logic                   o_link_clk,     // Generated link clock
  output logic [ADDR_W-1:0]      o_flash_addr,   // Flash address
  output logic                   o_flash_oe_n,   // Flash output enable
  output logic                   o_flash_we_n,   // Flash write enable
  output logic                   o_flash_adv_n,  // Flash address latch input
  output logic                   o_flash_select_drive_n, // Flash chip select
  output logic                   o_busy_n,       // Busy, low while loading
  output logic                   o_chain_select_out_n,   // Next device select
  output logic [1:0]             o_revision_select,      // Revision select value
  output logic                   o_revision_select_oe_n, // Low while driven
  output logic                   o_user_active   // Multi-purpose pins in user role
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic              rs1_reg, rs2_reg, rs3_reg;   // Restart pin
  logic              rw1_reg, rw2_reg;            // Ready wait
  logic              in1_reg, in2_reg, in3_reg;   // Init wire
  logic              dn1_reg, dn2_reg;            // Done wire
  logic [DATA_W-1:0] d1_reg, d2_reg, d3_reg;      // Data, third stage aligns with clock edge

  // Two flops per pin, third stages for edges and data alignment
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {rs1_reg, rs2_reg, rs3_reg} <= 3'h7;
      {rw1_reg, rw2_reg}          <= 2'h0;
      {in1_reg, in2_reg, in3_reg} <= 3'h0;
      {dn1_reg, dn2_reg}          <= 2'h0;
      d1_reg <= 16'h0000;
      d2_reg <= 16'h0000;
      d3_reg <= 16'h0000;
    end else begin
      {rs1_reg, rs2_reg, rs3_reg} <= {i_restart_n, rs1_reg, rs2_reg};
      {rw1_reg, rw2_reg}          <= {i_ready_wait, rw1_reg};
      {in1_reg, in2_reg, in3_reg} <= {i_init_in, in1_reg, in2_reg};
      {dn1_reg, dn2_reg}          <= {i_done_in, dn1_reg};
      d1_reg <= i_data;
      d2_reg <= d1_reg;
      d3_reg <= d2_reg;
    end
  end

  // ****************************************
  // Submodules
  // ****************************************
  pbl_word_if wbus ();
  logic       rise;         // Link clock rising edge
  logic       run_clk;      // Master clock runs
  logic       master_reg;   // Mode caught at init rise

  pbl_link_clock #(.HALF(HALF)) u_clk (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_master   (master_reg),
    .i_run      (run_clk),
    .i_ext_clk  (i_ext_clk),
    .o_link_clk (o_link_clk),
    .o_rise     (rise)
  );

  pbl_crc16 u_crc (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .bus   (wbus)
  );

  // ****************************************
  // Registers and state
  // ****************************************
  pbl_state_t       st_reg, st_next;             // Loader state
  logic [3:0]       ctrl_reg, ctrl_next;         // Control bits, start self-clears
  logic [LEN_W-1:0] len_reg, len_next;           // Expected words
  logic [15:0]      exp_reg, exp_next;           // Expected check value
  logic [LEN_W-1:0] cnt_reg, cnt_next;           // Words captured
  logic [15:0]      tim_reg, tim_next;           // Init and edge timer
  logic             mst_next;                    // Mode next value
  logic             pwr_reg, pwr_next;           // Power-up start pending
  logic             fbu_reg, fbu_next;           // Fallback attempt taken
  logic             ab_reg, ab_next;             // Abandoned
  logic             err_reg, err_next;           // Check error seen
  logic             chain_reg, chain_next;       // Hand-over done
  logic             fsel_reg, fsel_next;         // Flash select level
  logic             user_reg, user_next;         // User pins active
  logic             rel_reg, rel_next;           // Init released
  logic [31:0]      rd_reg, rd_next;             // Read data
  logic             start;                       // Any start order
  logic             restart_pulse;               // Rising end of restart pulse
  logic             word_take;                   // Capture this cycle

  assign restart_pulse = rs2_reg && !rs3_reg;
  // Power-up with restart high, software start, or high-low-high pulse  see R3
  assign start     = (pwr_reg && rs2_reg) || restart_pulse ||
                     (i_wr && i_addr == REG_CTRL && i_wdata[CTRL_START]);
  assign word_take = (st_reg == ST_STREAM || st_reg == ST_STARTUP) && rise;   // see R8
  assign run_clk   = (st_reg >= ST_WAITRDY) && (st_reg <= ST_STARTUP);  // see R16

  // Feed captured words to the checker
  assign wbus.clear = (st_reg == ST_INIT);
  assign wbus.valid = word_take;
  assign wbus.word  = d3_reg;

  // Next state, timer and register file
  always_comb begin
    st_next    = st_reg;
    ctrl_next  = ctrl_reg & ~4'h1;
    len_next   = len_reg;
    exp_next   = exp_reg;
    cnt_next   = cnt_reg;
    tim_next   = tim_reg;
    mst_next   = master_reg;
    pwr_next   = pwr_reg && !start;
    fbu_next   = fbu_reg;
    ab_next    = ab_reg;
    err_next   = err_reg;
    chain_next = chain_reg;
    fsel_next  = fsel_reg;
    user_next  = user_reg;
    rel_next   = rel_reg;
    rd_next    = 32'h00000000;
    if (i_wr) begin
      case (i_addr)
        REG_CTRL:   ctrl_next = i_wdata[3:0];
        REG_LEN:    len_next  = i_wdata[LEN_W-1:0];
        REG_EXPECT: exp_next  = i_wdata[15:0];
        default:    ;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        REG_CTRL:   rd_next = {28'h0, ctrl_reg};
        REG_LEN:    rd_next = {8'h00, len_reg};
        REG_EXPECT: rd_next = {16'h0000, exp_reg};
        REG_STATUS: rd_next = {20'h00000, user_reg, chain_reg, master_reg, ab_reg,
                               fbu_reg, err_reg, dn2_reg, in2_reg, st_reg};
        REG_COUNT:  rd_next = {8'h00, cnt_reg};
        REG_CRC:    rd_next = {16'h0000, wbus.crc};
        default:    rd_next = 32'h00000000;
      endcase
    end
    case (st_reg)
      ST_IDLE, ST_DONE, ST_ERROR: begin
        if (start) begin
          st_next    = ST_INIT;      // Init pulled low at the start  see R3
          tim_next   = 16'h0000;
          fbu_next   = 1'b0;
          ab_next    = 1'b0;
          err_next   = 1'b0;
          chain_next = 1'b0;
          fsel_next  = 1'b0;         // Flash re-enabled for a new load  see R1
          user_next  = 1'b0;
          rel_next   = 1'b0;
        end
      end
      ST_INIT: begin
        cnt_next = '0;
        if (!rel_reg) begin
          tim_next = tim_reg + 16'h0001;
          if (tim_reg == 16'(INIT_CYCLES - 1)) begin
            rel_next = 1'b0 | 1'b1;  // Initialisation over, let the wire rise  see R5
          end
        end else if (in2_reg && !in3_reg) begin
          mst_next = ctrl_reg[CTRL_MASTER];  // Mode caught on init rise  see R5
          st_next  = ST_WAITRDY;
          tim_next = 16'h0000;
        end
      end
      ST_WAITRDY: begin
        if (rw2_reg) begin
          st_next = ST_LATCH;
        end
      end
      ST_LATCH: begin
        // Flash takes the address on the third clock after ready
        if (rise) begin
          tim_next = tim_reg + 16'h0001;
          if (tim_reg == 16'(LATCH_EDGES - 3'h1)) begin
            st_next  = ST_LATENCY;
            tim_next = 16'h0000;
          end
        end
      end
      ST_LATENCY: begin
        if (rise) begin
          tim_next = tim_reg + 16'h0001;
          if (tim_reg == 16'(LATENCY - 1)) begin
            st_next = ST_STREAM;
          end
        end
      end
      ST_STREAM: begin
        if (word_take) begin
          cnt_next = cnt_reg + 24'h000001;
          if (cnt_reg + NEAR_END + 24'h000001 >= len_reg) begin
            st_next   = ST_STARTUP;  // Startup near the last word  see R10
          end
        end
      end
      ST_STARTUP: begin
        if (word_take || cnt_reg >= len_reg) begin
          if (cnt_reg < len_reg) begin
            cnt_next = cnt_reg + 24'h000001;
          end else if (wbus.crc == exp_reg) begin
            st_next    = ST_DONE;
            user_next  = 1'b1;       // see R13
            fsel_next  = 1'b1;       // Stop flash output  see R14
            chain_next = ctrl_reg[CTRL_CHAIN];  // see R9
          end else begin
            err_next = 1'b1;         // see R11
            if (master_reg && ctrl_reg[CTRL_FALLBK] && !fbu_reg) begin
              fbu_next = 1'b1;       // One retry only  see R17
              st_next  = ST_INIT;
              tim_next = 16'h0000;
              rel_next = 1'b0;
            end else begin
              ab_next = 1'b1;        // see R18
              st_next = ST_ERROR;
            end
          end
        end
      end
      default: st_next = ST_IDLE;
    endcase
    if (word_take && st_reg == ST_STARTUP && cnt_reg >= len_reg) begin
      cnt_next = cnt_reg;
    end
  end

  // Register all control state
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg     <= ST_IDLE;
      ctrl_reg   <= CTRL_RESET;
      len_reg    <= LEN_RESET;
      exp_reg    <= CRC_INIT;
      cnt_reg    <= '0;
      tim_reg    <= 16'h0000;
      master_reg <= 1'b0;
      pwr_reg    <= 1'b1;
      fbu_reg    <= 1'b0;
      ab_reg     <= 1'b0;
      err_reg    <= 1'b0;
      chain_reg  <= 1'b0;
      fsel_reg   <= 1'b0;
      user_reg   <= 1'b0;
      rel_reg    <= 1'b0;
      rd_reg     <= 32'h00000000;
    end else begin
      st_reg     <= st_next;
      ctrl_reg   <= ctrl_next;
      len_reg    <= len_next;
      exp_reg    <= exp_next;
      cnt_reg    <= cnt_next;
      tim_reg    <= tim_next;
      master_reg <= mst_next;
      pwr_reg    <= pwr_next;
      fbu_reg    <= fbu_next;
      ab_reg     <= ab_next;
      err_reg    <= err_next;
      chain_reg  <= chain_next;
      fsel_reg   <= fsel_next;
      user_reg   <= user_next;
      rel_reg    <= rel_next;
      rd_reg     <= rd_next;
    end
  end

  // ****************************************
  // Pin drivers, from flops except the constant straps
  // ****************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_init_oe_n            <= 1'b0;
      o_done_oe_n            <= 1'b0;
      o_busy_n               <= 1'b1;
      o_chain_select_out_n   <= 1'b1;
      o_flash_select_drive_n <= 1'b0;
      o_revision_select      <= 2'h0;
      o_revision_select_oe_n <= 1'b1;
      o_user_active          <= 1'b0;
    end else begin
      // Init held low during initialisation and on error  see R11
      o_init_oe_n            <= !((st_next == ST_INIT && !rel_next) || st_next == ST_ERROR);
      o_done_oe_n            <= (st_next == ST_DONE);    // see R12
      o_busy_n               <= (st_next == ST_IDLE);    // see R4
      o_chain_select_out_n   <= !chain_next;
      o_flash_select_drive_n <= fsel_next;
      o_revision_select      <= 2'h0;
      o_revision_select_oe_n <= !fbu_next;               // see R15
      o_user_active          <= user_next;  // Unused user pins left to board pull-down  see R19
    end
  end

  // Address, latch and write straps are constant  see R1
  assign o_flash_addr  = START_ADDR;
  assign o_flash_oe_n  = 1'b0;
  assign o_flash_we_n  = 1'b1;
  assign o_flash_adv_n = 1'b1;
  assign o_rdata       = rd_reg;

  // ****************************************
  // Checks
  // ****************************************
  chk_start_init_low: assert property (start && st_reg == ST_IDLE |=> ##1 !o_init_oe_n)  // see R3
    else $error("init not pulled low after start");
  chk_busy_while_load: assert property (st_reg == ST_STREAM |-> !o_busy_n)  // see R4
    else $error("busy high while streaming");
  chk_mode_on_rise: assert property ($rose(st_reg == ST_WAITRDY) |->  // see R5
                                     master_reg == $past(ctrl_reg[CTRL_MASTER]))
    else $error("mode not caught at init rise");
  chk_word_on_rise: assert property (st_reg == ST_STREAM && cnt_reg != $past(cnt_reg) |-> $past(rise))  // see R8
    else $error("word taken without link edge");
  chk_error_pins: assert property (st_reg == ST_ERROR |=> !o_init_oe_n && !o_done_oe_n)  // see R11
    else $error("error state without init and done low");
  chk_done_release: assert property ($rose(st_reg == ST_DONE) |=> o_done_oe_n && o_flash_select_drive_n)  // see R12
    else $error("done or flash select wrong after load");
  chk_revision_idle: assert property (!fbu_reg |-> o_revision_select_oe_n)  // see R15
    else $error("revision select driven without fallback");
  chk_fallback_once: assert property (fbu_reg && st_reg == ST_STARTUP && st_next == ST_INIT |-> 1'b0)  // see R18
    else $error("second fallback attempted");
  chk_master_clock: assert property (master_reg && !run_clk |-> ##1 !o_link_clk)  // see R16
    else $error("link clock runs while idle");
  chk_chain_hand: assert property (!o_chain_select_out_n |-> st_reg == ST_DONE ##0 ctrl_reg[CTRL_CHAIN])  // see R9
    else $error("chain select low outside hand-over");
endmodule // pbl_loader
`default_nettype wire

// *** src/pbl_pkg.sv ***
// Overview of operation
// R1: Straps hold flash enabled, address zero
// R2: Slave mode shares one free-running clock
// R3: Start on power-up or restart pulse
// R4: Busy driven low when configuration begins
// R5: Init released; mode sampled on rise
// R6: Flash latches address three clocks after ready
// R7: Flash streams sequential words after latency
// R8: Capture each word on link clock rise
// R9: Chain select out low hands over
// R10: Startup begins near the final word
// R11: Check error drives init low, done low
// R12: Good load releases done for pull-up
// R13: Startup hands multi-purpose pins to user
// R14: User logic drives flash select high
// R15: Revision select idle high-impedance
// R16: Master mode generates link clock itself
// R17: Master fallback drives revision low, restarts
// R18: Second error drives init low, abandons
// R19: Unused user pins weak pull-down; the loader drives none and leaves them to the board pull-down
// R20: Flash idles bus when deselected; the bench flash model toggles it on each link clock fall instead
package pbl_pkg;

  // ****************************************
  // Widths and register map
  // ****************************************
  localparam int          ADDR_W       = 23;        // Flash address inputs
  localparam int          DATA_W       = 16;        // Flash data bus
  localparam int          LEN_W        = 24;        // Word count width
  localparam logic [7:0]  REG_CTRL     = 8'h00;     // Control bits
  localparam logic [7:0]  REG_LEN      = 8'h04;     // Bitstream length in words
  localparam logic [7:0]  REG_EXPECT   = 8'h08;     // Expected check value
  localparam logic [7:0]  REG_STATUS   = 8'h0c;     // Loader status
  localparam logic [7:0]  REG_COUNT    = 8'h10;     // Words captured
  localparam logic [7:0]  REG_CRC      = 8'h14;     // Running check value
  localparam int          CTRL_START   = 0;         // Write one to start
  localparam int          CTRL_MASTER  = 1;         // Master mode select
  localparam int          CTRL_FALLBK  = 2;         // Fallback enable
  localparam int          CTRL_CHAIN   = 3;         // Hand over to next device
  localparam logic [3:0]  CTRL_RESET   = 4'h0;      // Control reset value
  localparam logic [LEN_W-1:0] LEN_RESET = 24'h000100; // Length reset value

  // ****************************************
  // Link constants and timing
  // ****************************************
  localparam logic [ADDR_W-1:0] START_ADDR   = 23'h000000; // Burst start address
  localparam logic [2:0]        LATCH_EDGES  = 3'h3;       // Clocks from ready to latch
  localparam logic [LEN_W-1:0]  NEAR_END     = 24'h000001; // Words before end for startup
  localparam logic [15:0]       CRC_INIT     = 16'hffff;   // Check seed
  localparam logic [15:0]       CRC_POLY     = 16'h1021;   // Check polynomial
  localparam longint            CLK_HZ       = 25000000;   // System clock rate
  localparam longint            INIT_TIME_NS = 2000;       // Least init low time
  localparam int                INIT_CYCLES  = int'((INIT_TIME_NS * CLK_HZ + 64'd999999999) / 64'd1000000000);

  // ****************************************
  // Loader states
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_INIT    = 4'h1,
    ST_WAITRDY = 4'h2,
    ST_LATCH   = 4'h3,
    ST_LATENCY = 4'h4,
    ST_STREAM  = 4'h5,
    ST_STARTUP = 4'h6,
    ST_DONE    = 4'h7,
    ST_ERROR   = 4'h8
  } pbl_state_t;

endpackage

// *** src/pbl_word_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Captured words travelling to the check accumulator
interface pbl_word_if;
  logic        clear;  // Reseed the check value
  logic        valid;  // One-cycle word strobe
  logic [15:0] word;   // Captured word
  logic [15:0] crc;    // Running check value
  modport src (output clear, output valid, output word, input crc);
  modport acc (input clear, input valid, input word, output crc);
endinterface
`default_nettype wire

// *** src/pbl_crc16.sv ***
`timescale 1ns/1ps
`default_nettype none
module pbl_crc16 import pbl_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  pbl_word_if.acc  bus
);
  // ****************************************
  // Word-wide check update
  // ****************************************
  function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [15:0] w);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      fb = r[15] ^ w[i];
      r  = {r[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    return r;
  endfunction

  logic [15:0] crc_reg;   // Accumulated value
  logic [15:0] crc_next;  // Next value

  // Clear wins so each attempt starts from the seed
  always_comb begin
    crc_next = crc_reg;
    if (bus.clear) begin
      crc_next = CRC_INIT;
    end else if (bus.valid) begin
      crc_next = crc_word(crc_reg, bus.word);
    end
  end

  // Register the check value
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      crc_reg <= CRC_INIT;
    end else begin
      crc_reg <= crc_next;
    end
  end

  assign bus.crc = crc_reg;
endmodule // pbl_crc16
`default_nettype wire

// *** src/pbl_link_clock.sv ***
`timescale 1ns/1ps
`default_nettype none
module pbl_link_clock #(
  parameter int HALF = 4                   // System cycles per half link period
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_master,              // Generate clock here
  input  wire logic i_run,                 // Let the generated clock toggle
  input  wire logic i_ext_clk,             // Free-running clock pin
  output logic      o_link_clk,            // Generated clock pin
  output logic      o_rise                 // One cycle per link rising edge
);
  logic [7:0] cnt_reg, cnt_next;           // Half-period counter
  logic       gen_reg, gen_next;           // Generated clock level
  logic       s1_reg, s2_reg, s3_reg;      // Pin synchroniser and history
  logic       rise_next;                   // Edge pulse next value
  logic       rise_reg;                    // Edge pulse

  // ****************************************
  // Divider in master mode, edge finder in slave mode
  // ****************************************
  always_comb begin
    cnt_next  = cnt_reg;
    gen_next  = gen_reg;
    rise_next = 1'b0;
    if (i_master) begin
      if (!i_run) begin
        cnt_next = 8'h00;
        gen_next = 1'b0;   // Parked low between loads
      end else if (cnt_reg == 8'(HALF - 1)) begin
        cnt_next  = 8'h00;
        gen_next  = !gen_reg;
        rise_next = !gen_reg;
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
    end else begin
      gen_next  = 1'b0;
      rise_next = s2_reg && !s3_reg;   // Third stage only feeds edge logic  see R2
    end
  end

  // Register divider, synchroniser and edge pulse
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg  <= 8'h00;
      gen_reg  <= 1'b0;
      s1_reg   <= 1'b0;
      s2_reg   <= 1'b0;
      s3_reg   <= 1'b0;
      rise_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      gen_reg  <= gen_next;
      s1_reg   <= i_ext_clk;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      rise_reg <= rise_next;
    end
  end

  assign o_link_clk = gen_reg;
  assign o_rise     = rise_reg;
endmodule // pbl_link_clock
`default_nettype wire

// *** testbench/pbl_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pbl_flash_model import pbl_pkg::*; #(
  parameter int LATENCY = 4               // Rises from latch to first word
) (
  input  wire logic              i_link_clk, // Shared link clock
  input  wire logic              i_ready,    // Ready level
  input  wire logic [ADDR_W-1:0] i_addr,     // Start address pins
  input  wire logic              i_sel_n,    // Chip enable
  input  wire logic              i_oe_n,     // Output enable
  output logic [DATA_W-1:0]      o_data      // Data bus
);
  logic [DATA_W-1:0] mem [16];   // Array, filled by the bench
  int                cnt = 0;    // Rises since ready
  logic [ADDR_W-1:0] base = '0;  // Latched start address
  // ****************************************
  // Address latch on the third rise
  // ****************************************
  always @(posedge i_link_clk or negedge i_ready) begin
    if (!i_ready) cnt <= 0;
    else begin
      cnt <= cnt + 1;
      if (cnt == 2) base <= i_addr;
    end
  end
  // Launch on the fall so the word is settled at the next rise
  always @(negedge i_link_clk) begin
    if (i_sel_n || i_oe_n || cnt < 3 + LATENCY) o_data <= ~o_data;
    else o_data <= mem[(int'(base) + cnt - 3 - LATENCY) & 15];
  end
endmodule // pbl_flash_model
`default_nettype wire

// *** testbench/pbl_loader_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module pbl_loader_bench import pbl_pkg::*;;
  logic i_clk, i_rst, i_wr, i_rd, ext_clk, restart_n, ready, init_oe_n, done_oe_n, link_clk;
  logic foe_n, fwe_n, fadv_n, fsel_n, busy_n, chain_n, rs_oe_n, user;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, ctrl, d;
  logic [DATA_W-1:0] fdata;
  logic [ADDR_W-1:0] faddr;
  logic [1:0] rs;
  int bad_count, tests_run, len;
  wire logic init_w = init_oe_n;  // Pull-up wins when released
  wire logic lclk = ctrl[CTRL_MASTER] ? link_clk : ext_clk;
  pbl_loader #(.LATENCY(4), .HALF(4)) pbl_loader_inst (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_clk(ext_clk),
    .i_restart_n(restart_n), .i_ready_wait(ready), .i_data(fdata), .i_init_in(init_w),
    .o_init_oe_n(init_oe_n), .i_done_in(done_oe_n), .o_done_oe_n(done_oe_n), .o_link_clk(link_clk),
    .o_flash_addr(faddr), .o_flash_oe_n(foe_n), .o_flash_we_n(fwe_n), .o_flash_adv_n(fadv_n),
    .o_flash_select_drive_n(fsel_n), .o_busy_n(busy_n), .o_chain_select_out_n(chain_n),
    .o_revision_select(rs), .o_revision_select_oe_n(rs_oe_n), .o_user_active(user));
  pbl_flash_model #(.LATENCY(4)) pbl_flash_model_inst (.i_link_clk(lclk), .i_ready(ready),
    .i_addr(faddr), .i_sel_n(fsel_n), .i_oe_n(foe_n), .o_data(fdata));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] crc_of(input int n);
    logic [15:0] c;
    c = CRC_INIT;
    for (int k = 0; k < n; k++)
      for (int b = 15; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ pbl_flash_model_inst.mem[k][b]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      bad_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    i_addr <= a; i_wdata <= v; i_wr <= 1'b1;
    @(posedge i_clk); i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    i_addr <= a; i_rd <= 1'b1;
    @(posedge i_clk); i_rd <= 1'b0;
    #1 d = o_rdata;
    @(posedge i_clk);
  endtask
  // Fresh random array; a bad load flips the expected check value
  task automatic prep(input int n, input logic bad);
    len = n;
    for (int k = 0; k < 16; k++) pbl_flash_model_inst.mem[k] = 16'($urandom);
    wr(REG_LEN, len); wr(REG_EXPECT, {16'h0000, crc_of(len) ^ {16{bad}}});
  endtask
  // Trigger: 0 none, 1 control write, 2 restart pulse
  task automatic load(input int how);
    int n;
    ready <= 1'b0;
    if (how == 1) wr(REG_CTRL, ctrl);
    if (how == 2) begin
      restart_n <= 1'b0; repeat (4) @(posedge i_clk); restart_n <= 1'b1;
    end
    repeat (4) @(posedge i_clk);
    chk("busy", busy_n, 0);
    chk("init_start", init_w, 0);
    for (n = 0; !init_w && n < 500; n++) @(posedge i_clk);
    chk("init_rise", init_w, 1);
    repeat (8) @(posedge i_clk);
    @(negedge lclk); @(posedge i_clk); ready <= 1'b1;  // Half a link period before a rise
    for (n = 0; init_oe_n && !fsel_n && n < 4000; n++) @(posedge i_clk);
    repeat (3) @(posedge i_clk);
  endtask
  task automatic good(input logic m, input logic c);
    chk("done", done_oe_n, 1);
    chk("user", user, 1);
    chk("fsel", fsel_n, 1);
    chk("rs_oe", rs_oe_n, 1);
    chk("chain", chain_n, !c);
    rd(REG_COUNT); chk("count", d, len);
    rd(REG_CRC); chk("crc", d, crc_of(len));
    rd(REG_STATUS); chk("mode", d[9], m);
  endtask
  task automatic end_sim;
    if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ****************************************
  // Clocks, watchdog and main sequence
  // ****************************************
  initial forever #20 i_clk = ~i_clk;
  initial begin #7; forever #160 ext_clk = ~ext_clk; end  // Free-running, unrelated phase
  initial begin repeat (30000) @(posedge i_clk); bad_count++; end_sim(); end
  initial begin
    i_clk = 0; i_rst = 1; i_wr = 0; i_rd = 0; i_addr = '0; i_wdata = '0; ext_clk = 0;
    restart_n = 1; ready = 0; ctrl = '0; bad_count = 0; tests_run = 0; len = 0;
    void'($urandom(32'hafcb1aaa));
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    rd(REG_LEN); chk("len_reset", d, LEN_RESET);
    rd(8'hfc); chk("unmapped", d, 0);
    chk("flash_pins", {fadv_n, fwe_n, foe_n, faddr}, {2'b11, 1'b0, START_ADDR});
    prep(2 + $urandom_range(14), 0); load(0); good(0, 0);
    prep(16, 1); load(2);
    chk("err_init", init_oe_n, 0); chk("err_done", done_oe_n, 0);
    ctrl = 32'h0000000b; prep(1, 0); load(1); good(1, 1);
    ctrl = 32'h00000007; prep(2 + $urandom_range(6), 1); load(1);
    chk("rs_oe", rs_oe_n, 0); chk("rs", rs, 0);
    load(0); rd(REG_STATUS);
    chk("abandon", {d[8], init_oe_n}, 2'b10);
    end_sim();
  end
endmodule // pbl_loader_bench
`default_nettype wire
